// File: rtl/swr_pkg.sv
package swr_pkg;

    // register byte addresses, one aligned word each
    localparam logic [7:0] ADDR_SLEEP_CMD   = 8'h00;
    localparam logic [7:0] ADDR_NORMAL_CMD  = 8'h04;
    localparam logic [7:0] ADDR_SLEEP_CFG   = 8'h08;
    localparam logic [7:0] ADDR_PIN_CFG     = 8'h0C;
    localparam logic [7:0] ADDR_SUPPLY_CTRL = 8'h10;
    localparam logic [7:0] ADDR_ANALOG_CTRL = 8'h14;
    localparam logic [7:0] ADDR_STATUS      = 8'h18;
    localparam logic [7:0] ADDR_MASK        = 8'h1C;
    localparam logic [7:0] ADDR_STATE       = 8'h20;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // sleep configuration field
    localparam int SLP_REQ_BIT = 0;

    // supply_monitor_ctrl fields
    localparam int SUP_SUPERVISOR_EN = 0;
    localparam int SUP_RESET_OUT_EN  = 1;
    localparam int SUP_OSC32_EN      = 2;
    localparam int SUP_WAKE_EN       = 3;
    localparam logic [3:0] SUP_RST   = 4'hF;

    // analog shutdown controls, one enable per block
    localparam int AN_ADC    = 0;
    localparam int AN_CPUMP  = 1;
    localparam int AN_REF    = 2;
    localparam int AN_OPAMP  = 3;
    localparam int AN_DAC    = 4;
    localparam int AN_SWITCH = 5;
    localparam logic [5:0] ANALOG_RST = 6'h00;

    // pin configuration: fn [7:0], polarity [11:8], pullup [15:12], out [19:16]
    localparam int NUM_PINS   = 4;
    localparam int PC_POL_LSB = 8;
    localparam int PC_PU_LSB  = 12;
    localparam int PC_OUT_LSB = 16;
    localparam logic [19:0] PIN_CFG_RST = 20'h0_F000;

    // status and mask layout
    localparam int ST_LOW_SUPPLY = 0;
    localparam int ST_HF_LOCKED  = 1;
    localparam int ST_WAKE_PIN   = 2;
    localparam int ST_ALARM      = 3;
    localparam int ST_SLEEP_IN   = 4;
    localparam int NUM_EVT       = 5;
    localparam logic [4:0] STATUS_RST = 5'h00;
    localparam logic [4:0] MASK_RST   = 5'h1D;

    // clock-output start-up delay after the supervisor clears
    localparam int CLK_PERIOD_NS      = 10;
    localparam int STARTUP_TIMEOUT_US = 100;
    localparam int STARTUP_CYCLES_DEF =
        (STARTUP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {PIN_INPUT, PIN_SLEEP, PIN_WAKE, PIN_OUTPUT} swr_pin_fn_t;
    typedef enum logic {MODE_NORMAL, MODE_SLEEP} swr_mode_t;

    typedef struct packed {
        logic dvdd_low;
        logic wdog_expired;
        logic xtal_attached;
        logic clk32_ready;
        logic hf_locked;
        logic day_alarm;
    } swr_async_t;

    typedef struct packed {
        logic adc;
        logic charge_pump;
        logic reference;
        logic opamp;
        logic dac;
        logic switches;
        logic supervisor;
        logic osc32;
        logic wake_logic;
    } swr_power_t;

    typedef struct packed {
        swr_async_t  async_s1;
        swr_async_t  async_s2;
        logic [3:0]  pin_s1;
        logic [3:0]  pin_s2;
        logic [3:0]  pin_act_prev;
        logic        alarm_prev;
        logic        hf_prev;
        logic        aw_have;
        logic [7:0]  aw_addr;
        logic        w_have;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [19:0] pin_cfg;
        logic [3:0]  supply_ctrl;
        logic [5:0]  analog_ctrl;
        logic [4:0]  status;
        logic [4:0]  mask;
        logic        shutdown_flag;
        logic        pin_sleep;
        swr_mode_t   mode;
        logic [31:0] start_cnt;
        logic        clocks_on;
        logic        reset_n;
        logic        irq;
        swr_power_t  power;
        logic [3:0]  pin_oe;
        logic [3:0]  pin_pullup;
        logic [3:0]  pin_out;
    } swr_state_t;

endpackage

// File: rtl/swr_top.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// Notes on behaviour
// - after reset supervisor is enabled, all user pins inputs with pullups on
// - clock outputs start only after supervisor clears and start-up delay expires
// - after reset every interrupt source masked except the clock-locked flag
// - converter, pump, reference, amplifiers, dac and switches come up disabled
// - sleep powers down all but interface, registers, bandgap, fast clock and enabled keep-alives
// - each analog block has its own shutdown enable; bandgap has none
// - write to the sleep command address sets shutdown flag and sleeps
// - pin sleep request sleeps without touching flag, beats writes and wake
// - writing sleep request bit as one sets shutdown flag and sleeps
// - sleep equals pin sleep request OR shutdown flag
// - with flag clear, releasing pin sleep returns to normal mode
// - normal command write clears flag when pin sleep is released
// - wake pin or day alarm leaves sleep when pin sleep is released
// - wake event in normal mode only sets a status bit
// - reset output low on por, monitor trip, watchdog, crystal, slow clock unready
// - with reset output disabled, low supply only raises the status flag
// - reset output enable one lets the detector pull reset; default one
module swr_top
    import swr_pkg::*;
#(
    parameter int unsigned STARTUP_CYCLES = STARTUP_CYCLES_DEF
)(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire swr_async_t  async_in,
    input  wire logic [3:0]  user_pin_in,
    output logic [3:0]       user_pin_out,
    output logic [3:0]       user_pin_oe,
    output logic [3:0]       user_pin_pullup,
    output logic             fast_clock_en,
    output logic             slow_clock_out_en,
    output swr_power_t       power,
    output logic             reset_out_n,
    output logic             irq
);

    // a zero delay would wrap the terminal count to all ones and hold the clocks off for 2^32 cycles
    if (STARTUP_CYCLES < 1)
    begin : g_bad_startup
        $error("STARTUP_CYCLES must be at least one");
    end

    swr_state_t  s_reg;
    swr_state_t  s_next;
    logic        wr_fire;
    logic        wr_sleep;
    logic        wr_normal;
    logic [7:0]  wr_addr;
    logic [31:0] wr_bits;
    logic [4:0]  st_clr;
    logic [4:0]  evt;
    logic [3:0]  pin_act;
    logic [3:0]  wake_rise;
    logic        pin_sleep_c;
    logic        wake_evt;
    logic        sup_en;
    logic        low_seen;
    logic        shut_c;
    logic [31:0] rd_data;
    logic [1:0]  rd_resp;
    logic [7:0]  rd_addr;
    logic [31:0] mg_pin;
    logic [31:0] mg_sup;
    logic [31:0] mg_an;
    logic [31:0] mg_mask;

    // byte-lane merge for partial writes
    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_val;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return res;
    endfunction

    // read mux, word aligned, unmapped answers slverr
    always_comb
    begin
        rd_addr = {s_axi_araddr[7:2], 2'b00};
        rd_data = 32'h0000_0000;
        rd_resp = RESP_OKAY;
        unique case (rd_addr)
            ADDR_SLEEP_CMD,
            ADDR_NORMAL_CMD:  rd_data = 32'h0000_0000;
            ADDR_SLEEP_CFG:   rd_data = {31'h0000_0000, s_reg.shutdown_flag};
            ADDR_PIN_CFG:     rd_data = {12'h000, s_reg.pin_cfg};
            ADDR_SUPPLY_CTRL: rd_data = {28'h000_0000, s_reg.supply_ctrl};
            ADDR_ANALOG_CTRL: rd_data = {26'h000_0000, s_reg.analog_ctrl};
            ADDR_STATUS:      rd_data = {27'h000_0000, s_reg.status};
            ADDR_MASK:        rd_data = {27'h000_0000, s_reg.mask};
            ADDR_STATE:       rd_data = {27'h000_0000, s_reg.reset_n, s_reg.clocks_on,
                                         s_reg.pin_sleep, s_reg.shutdown_flag,
                                         s_reg.mode == MODE_SLEEP};
            default:          rd_resp = RESP_SLVERR;
        endcase
    end

    // all next-state logic
    always_comb
    begin
        s_next    = s_reg;
        wr_sleep  = 1'b0;
        wr_normal = 1'b0;
        st_clr    = 5'h00;
        wr_addr   = {s_reg.aw_addr[7:2], 2'b00};
        wr_bits   = merge_bytes(32'h0000_0000, s_reg.wdata, s_reg.wstrb);
        wr_fire   = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
        // merged register words; a call result cannot be sliced directly
        mg_pin    = merge_bytes({12'h000, s_reg.pin_cfg}, s_reg.wdata, s_reg.wstrb);
        mg_sup    = merge_bytes({28'h000_0000, s_reg.supply_ctrl}, s_reg.wdata, s_reg.wstrb);
        mg_an     = merge_bytes({26'h000_0000, s_reg.analog_ctrl}, s_reg.wdata, s_reg.wstrb);
        mg_mask   = merge_bytes({27'h000_0000, s_reg.mask}, s_reg.wdata, s_reg.wstrb);

        // two-flop synchronisers; only stage two is looked at
        s_next.async_s1 = async_in;
        s_next.async_s2 = s_reg.async_s1;
        s_next.pin_s1   = user_pin_in;
        s_next.pin_s2   = s_reg.pin_s1;

        // pin function decode, either polarity via the polarity bit
        pin_act     = s_reg.pin_s2 ^ s_reg.pin_cfg[PC_POL_LSB +: NUM_PINS];
        pin_sleep_c = 1'b0;
        wake_rise   = 4'h0;
        for (int p = 0; p < NUM_PINS; p++)
        begin
            if (swr_pin_fn_t'(s_reg.pin_cfg[2*p +: 2]) == PIN_SLEEP)
            begin
                pin_sleep_c = pin_sleep_c | pin_act[p];
            end
            if (swr_pin_fn_t'(s_reg.pin_cfg[2*p +: 2]) == PIN_WAKE)
            begin
                wake_rise[p] = pin_act[p] & ~s_reg.pin_act_prev[p];
            end
        end
        s_next.pin_act_prev = pin_act;
        s_next.alarm_prev   = s_reg.async_s2.day_alarm;
        s_next.hf_prev      = s_reg.async_s2.hf_locked;

        // write address and data taken independently, in either order
        if (s_reg.awready && s_axi_awvalid)
        begin
            s_next.aw_have = 1'b1;
            s_next.aw_addr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid)
        begin
            s_next.w_have = 1'b1;
            s_next.wdata  = s_axi_wdata;
            s_next.wstrb  = s_axi_wstrb;
        end
        if (s_reg.bvalid && s_axi_bready)
        begin
            s_next.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            s_next.aw_have = 1'b0;
            s_next.w_have  = 1'b0;
            s_next.bvalid  = 1'b1;
            s_next.bresp   = RESP_OKAY;
            unique case (wr_addr)
                ADDR_SLEEP_CMD:   wr_sleep = 1'b1;
                ADDR_NORMAL_CMD:  wr_normal = 1'b1;
                ADDR_SLEEP_CFG:   wr_sleep = wr_bits[SLP_REQ_BIT];
                ADDR_PIN_CFG:     s_next.pin_cfg = mg_pin[19:0];
                ADDR_SUPPLY_CTRL: s_next.supply_ctrl = mg_sup[3:0];
                ADDR_ANALOG_CTRL: s_next.analog_ctrl = mg_an[5:0];
                ADDR_STATUS:      st_clr = wr_bits[4:0];
                ADDR_MASK:        s_next.mask = mg_mask[4:0];
                ADDR_STATE:       s_next.bresp = RESP_OKAY;
                default:          s_next.bresp = RESP_SLVERR;
            endcase
        end
        // one write in flight: hold both readies low until the response is taken
        s_next.awready = !s_next.aw_have && !s_next.bvalid;
        s_next.wready  = !s_next.w_have && !s_next.bvalid;

        // read channel, data captured on the address handshake
        if (s_reg.rvalid && s_axi_rready)
        begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && s_axi_arvalid)
        begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd_data;
            s_next.rresp  = rd_resp;
        end
        s_next.arready = !s_next.rvalid;

        // shutdown flag: wake clears, command clears, sleep writes set last
        sup_en   = s_reg.supply_ctrl[SUP_SUPERVISOR_EN];
        wake_evt = ((|wake_rise) && s_reg.supply_ctrl[SUP_WAKE_EN])
                   || (s_reg.async_s2.day_alarm && !s_reg.alarm_prev);
        shut_c   = s_reg.shutdown_flag;
        if (wake_evt && s_reg.mode == MODE_SLEEP && !pin_sleep_c)
        begin
            shut_c = 1'b0;
        end
        if (wr_normal && !pin_sleep_c)
        begin
            shut_c = 1'b0;
        end
        if (wr_sleep)
        begin
            shut_c = 1'b1;
        end
        s_next.shutdown_flag = shut_c;
        s_next.pin_sleep     = pin_sleep_c;
        // pin release with flag clear falls back to normal here
        s_next.mode = (pin_sleep_c || shut_c) ? MODE_SLEEP : MODE_NORMAL;

        // sticky events; a set in the clearing cycle survives
        low_seen = s_reg.async_s2.dvdd_low && sup_en;
        evt = 5'h00;
        evt[ST_LOW_SUPPLY] = low_seen;
        evt[ST_HF_LOCKED]  = s_reg.async_s2.hf_locked && !s_reg.hf_prev;
        evt[ST_WAKE_PIN]   = |wake_rise;
        evt[ST_ALARM]      = s_reg.async_s2.day_alarm && !s_reg.alarm_prev;
        evt[ST_SLEEP_IN]   = (s_next.mode == MODE_SLEEP) && (s_reg.mode == MODE_NORMAL);
        s_next.status = (s_reg.status & ~st_clr) | evt;
        s_next.irq    = |(s_next.status & ~s_next.mask);

        // reset output; detector path gated by the enable
        s_next.reset_n = !((low_seen && s_reg.supply_ctrl[SUP_RESET_OUT_EN])
                           || s_reg.async_s2.wdog_expired
                           || s_reg.async_s2.xtal_attached
                           || !s_reg.async_s2.clk32_ready);

        // start-up delay restarts while the supervisor is tripped
        if (!s_reg.clocks_on)
        begin
            if (low_seen)
            begin
                s_next.start_cnt = 32'h0000_0000;
            end
            else if (s_reg.start_cnt == 32'(STARTUP_CYCLES - 1))
            begin
                s_next.clocks_on = 1'b1;
            end
            else
            begin
                s_next.start_cnt = s_reg.start_cnt + 32'h0000_0001;
            end
        end

        // block power: analog follows its enable, all off in sleep
        unique case (s_next.mode)
            MODE_SLEEP:
            begin
                s_next.power.adc         = 1'b0;
                s_next.power.charge_pump = 1'b0;
                s_next.power.reference   = 1'b0;
                s_next.power.opamp       = 1'b0;
                s_next.power.dac         = 1'b0;
                s_next.power.switches    = 1'b0;
            end
            MODE_NORMAL:
            begin
                s_next.power.adc         = s_next.analog_ctrl[AN_ADC];
                s_next.power.charge_pump = s_next.analog_ctrl[AN_CPUMP];
                s_next.power.reference   = s_next.analog_ctrl[AN_REF];
                s_next.power.opamp       = s_next.analog_ctrl[AN_OPAMP];
                s_next.power.dac         = s_next.analog_ctrl[AN_DAC];
                s_next.power.switches    = s_next.analog_ctrl[AN_SWITCH];
            end
        endcase
        // keep-alive blocks stay up in sleep when enabled
        s_next.power.supervisor = s_next.supply_ctrl[SUP_SUPERVISOR_EN];
        s_next.power.osc32      = s_next.supply_ctrl[SUP_OSC32_EN];
        s_next.power.wake_logic = s_next.supply_ctrl[SUP_WAKE_EN];

        // user pin drivers
        for (int p = 0; p < NUM_PINS; p++)
        begin
            s_next.pin_oe[p] = swr_pin_fn_t'(s_next.pin_cfg[2*p +: 2]) == PIN_OUTPUT;
            s_next.pin_pullup[p] = s_next.pin_cfg[PC_PU_LSB + p] && !s_next.pin_oe[p];
            s_next.pin_out[p] = s_next.pin_cfg[PC_OUT_LSB + p];
        end
    end

    // state register; reset gives power-on defaults
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            // sync stages clear to not-ready so reset_out_n cannot blip high
            s_reg             <= '0;
            s_reg.pin_cfg     <= PIN_CFG_RST;
            s_reg.pin_pullup  <= 4'hF;
            s_reg.supply_ctrl <= SUP_RST;
            s_reg.analog_ctrl <= ANALOG_RST;
            s_reg.status      <= STATUS_RST;
            s_reg.mask        <= MASK_RST;
            s_reg.power.supervisor <= 1'b1;
            s_reg.power.osc32      <= 1'b1;
            s_reg.power.wake_logic <= 1'b1;
            s_reg.mode        <= MODE_NORMAL;
            s_reg.reset_n     <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // outputs straight from the state register; slow clock enable ANDs clocks_on with the osc32 enable
    assign s_axi_awready     = s_reg.awready;
    assign s_axi_wready      = s_reg.wready;
    assign s_axi_bvalid      = s_reg.bvalid;
    assign s_axi_bresp       = s_reg.bresp;
    assign s_axi_arready     = s_reg.arready;
    assign s_axi_rvalid      = s_reg.rvalid;
    assign s_axi_rdata       = s_reg.rdata;
    assign s_axi_rresp       = s_reg.rresp;
    assign user_pin_out      = s_reg.pin_out;
    assign user_pin_oe       = s_reg.pin_oe;
    assign user_pin_pullup   = s_reg.pin_pullup;
    assign fast_clock_en     = s_reg.clocks_on;
    assign slow_clock_out_en = s_reg.clocks_on && s_reg.supply_ctrl[SUP_OSC32_EN];
    assign power             = s_reg.power;
    assign reset_out_n       = s_reg.reset_n;
    assign irq               = s_reg.irq;

    // checks on the controller behaviour
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    property p_por_pins;
        $past(sys_rst) |-> user_pin_oe == 4'h0 && user_pin_pullup == 4'hF
                           && power.supervisor;
    endproperty
    a_por_pins: assert property (p_por_pins) else $error("pin defaults wrong");

    property p_clock_start;
        $rose(fast_clock_en) |-> $past(s_reg.start_cnt) == 32'(STARTUP_CYCLES - 1)
                                 && !$past(low_seen);
    endproperty
    a_clock_start: assert property (p_clock_start) else $error("clocks early");

    property p_por_mask;
        $past(sys_rst) |-> s_reg.mask == MASK_RST && !s_reg.mask[ST_HF_LOCKED];
    endproperty
    a_por_mask: assert property (p_por_mask) else $error("mask default wrong");

    property p_por_analog;
        $past(sys_rst) |-> !(power.adc || power.charge_pump || power.reference
                             || power.opamp || power.dac || power.switches);
    endproperty
    a_por_analog: assert property (p_por_analog) else $error("analog on at reset");

    property p_sleep_power;
        s_reg.mode == MODE_SLEEP |-> !(power.adc || power.dac || power.opamp)
                                     && power.supervisor == s_reg.supply_ctrl[0];
    endproperty
    a_sleep_power: assert property (p_sleep_power) else $error("block on in sleep");

    property p_sleep_cmd;
        wr_fire && wr_addr == ADDR_SLEEP_CMD |=> s_reg.shutdown_flag
                                                 && s_reg.mode == MODE_SLEEP;
    endproperty
    a_sleep_cmd: assert property (p_sleep_cmd) else $error("sleep command lost");

    property p_pin_keeps_flag;
        $rose(s_reg.pin_sleep) && !$past(wr_fire)
            |-> s_reg.shutdown_flag == $past(s_reg.shutdown_flag)
                && s_reg.mode == MODE_SLEEP;
    endproperty
    a_pin_keeps_flag: assert property (p_pin_keeps_flag) else $error("flag changed");

    property p_sleep_or;
        (s_reg.mode == MODE_SLEEP) == (s_reg.pin_sleep || s_reg.shutdown_flag);
    endproperty
    a_sleep_or: assert property (p_sleep_or) else $error("sleep not or");

    property p_wake;
        wake_evt && s_reg.mode == MODE_SLEEP && !pin_sleep_c && !wr_sleep
            |=> !s_reg.shutdown_flag ##0 s_reg.mode == MODE_NORMAL || s_reg.pin_sleep;
    endproperty
    a_wake: assert property (p_wake) else $error("wake ignored");

    property p_reset_out;
        low_seen && s_reg.supply_ctrl[SUP_RESET_OUT_EN] |=> !reset_out_n;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("reset not pulled");

    property p_low_flag;
        low_seen && !s_reg.supply_ctrl[SUP_RESET_OUT_EN] |=> s_reg.status[ST_LOW_SUPPLY];
    endproperty
    a_low_flag: assert property (p_low_flag) else $error("low flag missing");

    c_sleep_cmd: cover property (wr_fire && wr_addr == ADDR_SLEEP_CMD);
    c_pin_sleep: cover property ($rose(s_reg.pin_sleep));
    c_wake_exit: cover property (s_reg.mode == MODE_SLEEP ##1 s_reg.mode == MODE_NORMAL);
    c_irq:       cover property ($rose(irq));

endmodule

// File: tb/swr_pins_model.sv
`timescale 1ns/1ps
module swr_pins_model (
    input  wire logic [3:0] host_drv,
    input  wire logic [3:0] host_en,
    input  wire logic [3:0] dut_out,
    input  wire logic [3:0] dut_oe,
    input  wire logic [3:0] dut_pu,
    output logic [3:0]      pin_lvl
);
    // device drive wins, then host; an undriven pin without a pullup reads the inverse of host_drv
    always_comb
        for (int i = 0; i < 4; i++)
            pin_lvl[i] = dut_oe[i] ? dut_out[i] : host_en[i] ? host_drv[i]
                : dut_pu[i] | ~host_drv[i];
endmodule

// File: tb/tb_swr_top.sv
`timescale 1ns/1ps
module tb_swr_top;
    import swr_pkg::*;
    logic clock = 0, sys_rst = 1, awv = 0, wv = 0, brd = 0, arv = 0, rrd = 0;
    logic [7:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdat, rd;
    logic [3:0] hd = '0, he = '0, lvl, p_out, p_oe, p_pu;
    logic awr, wr_rdy, bv, arr, rv, fclk, sclk, rst_n, irq;
    logic [1:0] br, rr, resp;
    swr_async_t ain = '0;
    swr_power_t pwr;
    int num_errors = 0, total_checks = 0, cyc = 0;
    always #5 clock = ~clock;
    swr_top #(.STARTUP_CYCLES(8)) u_dut (.clock(clock), .sys_rst(sys_rst),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
        .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .async_in(ain),
        .user_pin_in(lvl), .user_pin_out(p_out), .user_pin_oe(p_oe),
        .user_pin_pullup(p_pu), .fast_clock_en(fclk), .slow_clock_out_en(sclk),
        .power(pwr), .reset_out_n(rst_n), .irq(irq));
    swr_pins_model u_pins (.host_drv(hd), .host_en(he), .dut_out(p_out),
        .dut_oe(p_oe), .dut_pu(p_pu), .pin_lvl(lvl));
    task automatic summarize;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1;
        wv <= 1;
        brd <= 1;
        @(posedge clock);
        while (awv || wv || !bv)
        begin
            if (awr)
                awv <= 0;
            if (wr_rdy)
                wv <= 0;
            @(posedge clock);
        end
        brd <= 0;
        @(posedge clock);
    endtask
    task automatic rdx(input logic [7:0] a);
        ara <= a;
        arv <= 1;
        rrd <= 1;
        @(posedge clock);
        while (arv || !rv)
        begin
            if (arr)
                arv <= 0;
            @(posedge clock);
        end
        rd = rdat;
        resp = rr;
        rrd <= 0;
        @(posedge clock);
    endtask
    // inputs pass two sync flops and one compute edge
    task automatic settle;
        repeat (6) @(posedge clock);
    endtask
    // hang guard
    always @(posedge clock)
    begin
        cyc++;
        if (cyc > 5000)
        begin
            num_errors++;
            summarize();
        end
    end
    initial
    begin
        repeat (10) @(posedge clock);
        sys_rst <= 0;
        repeat (2) @(posedge clock);
        chk(fclk, 0);
        chk(rst_n, 0);
        chk({p_oe, p_pu, p_out}, 12'h0F0);
        rdx(ADDR_SUPPLY_CTRL); chk(rd, 32'h0000_000F);
        rdx(ADDR_MASK); chk(rd, 32'h0000_001D);
        rdx(ADDR_ANALOG_CTRL); chk(rd, 32'h0000_0000);
        ain.clk32_ready <= 1;
        repeat (20) @(posedge clock);
        chk({rst_n, fclk, sclk}, 3'b111);
        $display("test power-up done");
        wr(ADDR_ANALOG_CTRL, 32'h0000_003F);
        wr(ADDR_SLEEP_CMD, 32'h0000_0000);
        rdx(ADDR_STATE); chk(rd[2:0], 3'b011);
        chk({pwr.adc, pwr.dac, pwr.supervisor}, 3'b001);
        wr(ADDR_NORMAL_CMD, 32'h0000_0000);
        rdx(ADDR_STATE); chk(rd[2:0], 3'b000);
        chk({pwr.adc, pwr.switches}, 2'b11);
        wr(ADDR_SLEEP_CFG, 32'h0000_0001);
        rdx(ADDR_STATE); chk(rd[2:0], 3'b011);
        ain.day_alarm <= 1;
        settle();
        rdx(ADDR_STATE); chk(rd[2:0], 3'b000);
        rdx(ADDR_STATUS); chk(rd[ST_ALARM], 1);
        $display("test sleep and wake done");
        he <= 4'h1;
        hd <= 4'h1;
        wr(ADDR_PIN_CFG, 32'h0000_F001);
        settle();
        wr(ADDR_NORMAL_CMD, 32'h0000_0000);
        rdx(ADDR_STATE); chk(rd[2:0], 3'b101);
        hd <= 4'h0;
        settle();
        rdx(ADDR_STATE); chk(rd[2:0], 3'b000);
        $display("test pin sleep done");
        ain.dvdd_low <= 1;
        settle();
        chk(rst_n, 0);
        wr(ADDR_SUPPLY_CTRL, 32'h0000_000D);
        wr(ADDR_MASK, 32'h0000_0000);
        settle();
        chk({rst_n, irq}, 2'b11);
        rdx(ADDR_STATUS); chk(rd[ST_LOW_SUPPLY], 1);
        ain.dvdd_low <= 0;
        settle();
        wr(ADDR_STATUS, 32'h0000_001F);
        repeat (2) @(posedge clock);
        chk(irq, 0);
        rdx(8'h40); chk(resp, RESP_SLVERR);
        $display("test reset output done");
        summarize();
    end
endmodule
